/* File: inc/area_bus_pkg.sv */
package area_bus_pkg;

    localparam int          AREA_COUNT       = 8;
    localparam int          ADDR_W           = 4;

    // Byte addresses of the two registers and the derived status word.
    localparam logic [3:0]  WIDTH_SEL_OFFSET = 4'h0;
    localparam logic [3:0]  STATE_SEL_OFFSET = 4'h4;
    localparam logic [3:0]  BUS_STATUS_OFFSET = 4'h8;

    // Status word fields.
    localparam int          STATUS_WIDE_BIT  = 0;
    localparam int          STATUS_SCHIP_BIT = 1;

    // Reset values.
    localparam logic [7:0]  WIDTH_RESET_NARROW = 8'hff;
    localparam logic [7:0]  WIDTH_RESET_WIDE   = 8'h00;
    localparam logic [7:0]  STATE_RESET        = 8'hff;

    // Operating mode codes.
    localparam logic [2:0]  MODE_SINGLE_CHIP = 3'h7;

    // Access lengths in states.
    localparam logic [1:0]  STATES_SHORT = 2'h2;
    localparam logic [1:0]  STATES_LONG  = 2'h3;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TARGET_EXTERNAL,
        TARGET_ONCHIP_MEM,
        TARGET_INTERNAL_IO
    } target_t;

endpackage

/* File: logic/area_access_decode.sv */
module area_access_decode
    import area_bus_pkg::*;
(
    input  wire logic [7:0] width_bits,
    input  wire logic [7:0] state_bits,
    input  wire logic [2:0] area,
    input  wire target_t    target,
    input  wire logic       single_chip,
    input  wire logic [1:0] fixed_states,
    input  wire logic       fixed_wide,
    output logic            access_wide,
    output logic [1:0]      access_states
);
    // External areas only honour the per-area bits outside single-chip mode.
    wire ext_cfg = (target == TARGET_EXTERNAL) && !single_chip;
    wire sel_w   = width_bits[area];
    wire sel_s   = state_bits[area];

    assign access_wide   = ext_cfg ? !sel_w : fixed_wide;
    assign access_states = ext_cfg ? (sel_s ? STATES_LONG : STATES_SHORT)
                                   : fixed_states;
endmodule

/* File: logic/area_bus_config.sv */
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
module area_bus_config
    import area_bus_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                hw_standby,
    input  wire logic                sw_standby,
    input  wire logic [2:0]          op_mode,
    input  wire logic [area_bus_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [area_bus_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [2:0]          access_area,
    input  wire area_bus_pkg::target_t access_target,
    input  wire logic [1:0]          fixed_states,
    input  wire logic                fixed_wide,
    output logic                     bus_wide_mode,
    output logic                     port4_is_gpio,
    output logic                     access_wide,
    output logic [1:0]               access_states,
    output logic [7:0]               area_width_bits,
    output logic [7:0]               area_state_count_bits
);
    import area_bus_pkg::*;

    // Mode straps come from pins, so they pass four flops before use.
    logic [2:0] mode_s1_q, mode_s2_q, mode_s3_q, mode_q;
    logic [7:0] width_q, state_q;
    logic [ADDR_W-1:0] awaddr_q, araddr_q;
    logic [7:0] wdata_q;
    logic       wbyte_q;
    logic       aw_held_q, w_held_q;
    logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic       wide_q, gpio_q, acc_wide_q;
    logic [1:0] acc_states_q;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == WIDTH_SEL_OFFSET) || (a == STATE_SEL_OFFSET)
                 || (a == BUS_STATUS_OFFSET);
    endfunction

    wire mode_stable = (mode_s2_q == mode_s3_q);
    wire single_chip = (mode_q == MODE_SINGLE_CHIP);

    // Modes 2, 4 and 7 reset every area to 16-bit width, the others to 8-bit.
    wire        wide_mode_reset = (mode_q == 3'h2) || (mode_q == 3'h4) || (mode_q == 3'h7);
    wire [7:0]  width_init = wide_mode_reset ? WIDTH_RESET_WIDE
                                             : WIDTH_RESET_NARROW;

    // Hardware standby initialises like reset; software standby is not an init source.
    wire        init_regs = reset || hw_standby;

    wire        aw_take = s_axi_awvalid && awready_q;
    wire        w_take  = s_axi_wvalid && wready_q;
    wire        aw_have = aw_held_q || aw_take;
    wire        w_have  = w_held_q || w_take;
    wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [7:0]  wr_data = w_held_q ? wdata_q : s_axi_wdata[7:0];
    wire        wr_lane = w_held_q ? wbyte_q : s_axi_wstrb[0];
    wire        wr_fire = aw_have && w_have && !bvalid_q;
    wire        wr_width = wr_fire && wr_lane && (wr_addr == WIDTH_SEL_OFFSET);
    wire        wr_state = wr_fire && wr_lane && (wr_addr == STATE_SEL_OFFSET);
    wire        wr_ok = (wr_addr == WIDTH_SEL_OFFSET) || (wr_addr == STATE_SEL_OFFSET)
                     || (wr_addr == BUS_STATUS_OFFSET);

    wire        ar_take = s_axi_arvalid && arready_q;
    wire [31:0] status_word = {30'h0, single_chip, wide_q};
    wire [31:0] rd_value;
    assign rd_value = (s_axi_araddr == WIDTH_SEL_OFFSET) ? {24'h0, width_q} :
                      (s_axi_araddr == STATE_SEL_OFFSET) ? {24'h0, state_q} :
                      (s_axi_araddr == BUS_STATUS_OFFSET) ? status_word : 32'h0;

    // All-ones width register means every area is byte wide: 8-bit bus mode.
    wire        all_narrow = &width_q;

    wire        dec_wide;
    wire [1:0]  dec_states;

    area_access_decode u_decode (
        .width_bits    (width_q),
        .state_bits    (state_q),
        .area          (access_area),
        .target        (access_target),
        .single_chip   (single_chip),
        .fixed_states  (fixed_states),
        .fixed_wide    (fixed_wide),
        .access_wide   (dec_wide),
        .access_states (dec_states)
    );

    always_ff @(posedge ref_clk) begin
        mode_s1_q <= op_mode;
        mode_s2_q <= mode_s1_q;
        mode_s3_q <= mode_s2_q;
        if (mode_stable) begin
            mode_q <= mode_s3_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (init_regs) begin
            width_q <= width_init;
            state_q <= STATE_RESET;
        end else begin
            if (wr_width) begin
                width_q <= wr_data;
            end
            if (wr_state) begin
                state_q <= wr_data;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 8'h00;
            wbyte_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata[7:0];
                wbyte_q <= s_axi_wstrb[0];
            end
            aw_held_q <= aw_have && !wr_fire;
            w_held_q  <= w_have && !wr_fire;
            awready_q <= !aw_have && !bvalid_q && !awready_q;
            wready_q  <= !w_have && !bvalid_q && !wready_q;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else begin
            arready_q <= !rvalid_q && !arready_q && s_axi_arvalid;
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_value;
                rresp_q  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wide_q       <= 1'b0;
            gpio_q       <= 1'b0;
            acc_wide_q   <= 1'b0;
            acc_states_q <= STATES_LONG;
        end else begin
            // Single-chip mode has no external bus, so wide mode is cleared and port 4 is reported free.
            wide_q       <= !all_narrow && !single_chip;
            gpio_q       <= all_narrow || single_chip;
            acc_wide_q   <= dec_wide;
            acc_states_q <= dec_states;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign bus_wide_mode = wide_q;
    assign port4_is_gpio = gpio_q;
    assign access_wide   = acc_wide_q;
    assign access_states = acc_states_q;
    assign area_width_bits       = width_q;
    assign area_state_count_bits = state_q;
endmodule

/* File: bench/fixed_target_model.sv */
module fixed_target_model
    import area_bus_pkg::*;
(
    input  wire target_t access_target,
    output logic [1:0]   fixed_states,
    output logic         fixed_wide
);
    timeunit 1ns;
    timeprecision 1ps;
    // On-chip memory is a wide two-state target; everything else is narrow and slow.
    assign fixed_states = (access_target == TARGET_ONCHIP_MEM) ? STATES_SHORT : STATES_LONG;
    assign fixed_wide   = (access_target == TARGET_ONCHIP_MEM);
endmodule

/* File: bench/area_bus_config_chk.sv */
module area_bus_config_chk
    import area_bus_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       hw_standby,
    input wire logic       sw_standby,
    input wire logic [2:0] op_mode,
    input wire logic [2:0] access_area,
    input wire target_t    access_target,
    input wire logic [1:0] fixed_states,
    input wire logic       fixed_wide,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       bus_wide_mode,
    input wire logic       port4_is_gpio,
    input wire logic       access_wide,
    input wire logic [1:0] access_states,
    input wire logic [7:0] area_width_bits,
    input wire logic [7:0] area_state_count_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic [7:0] init_w = (op_mode inside {3'h2, 3'h4, 3'h7}) ? 8'h00 : 8'hff;
    wire logic       ext = (access_target == TARGET_EXTERNAL);
    a_narrow_frees_port: assert property (area_width_bits == 8'hff |=> port4_is_gpio && !bus_wide_mode)
        else $error("narrow width kept wide mode");
    a_any_zero_wide: assert property ((area_width_bits != 8'hff) && (op_mode != MODE_SINGLE_CHIP) |=> bus_wide_mode)
        else $error("zero width bit without wide mode");
    a_area_width_map: assert property (ext && bus_wide_mode |=> access_wide == !$past(area_width_bits[access_area]))
        else $error("area width wrong");
    a_area_state_map: assert property (ext && bus_wide_mode |=> access_states == ($past(area_state_count_bits[access_area]) ? 2'h3 : 2'h2))
        else $error("area state count wrong");
    a_fixed_internal: assert property (!ext |=> access_wide == $past(fixed_wide) && access_states == $past(fixed_states))
        else $error("internal access not fixed");
    a_hw_standby_init: assert property (hw_standby |=> area_width_bits == init_w && area_state_count_bits == 8'hff)
        else $error("hardware standby did not reinit");
    a_sw_standby_keep: assert property (sw_standby && !hw_standby |=> $rose(s_axi_bvalid) || ($stable(area_width_bits) && $stable(area_state_count_bits)))
        else $error("software standby changed registers");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule
bind area_bus_config area_bus_config_chk chk_u (.*);

/* File: bench/area_bus_config_tb.sv */
module area_bus_config_tb;
    import area_bus_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset = 1'b1, hw_standby = 1'b0, sw_standby = 1'b0;
    logic [2:0] op_mode = 3'h1, access_area = 3'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, access_states, fixed_states, rr;
    target_t access_target = TARGET_EXTERNAL;
    logic fixed_wide, bus_wide_mode, port4_is_gpio, access_wide;
    logic [7:0] area_width_bits, area_state_count_bits;
    int num_errors = 0;
    int checked = 0;
    always #2.5 ref_clk = ~ref_clk;
    area_bus_config dut_u (.*);
    fixed_target_model model_u (.*);
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] got);
        checked++;
        if (got !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, got);
        end
    endtask
    task automatic hang();
        num_errors++;
        $display("unexpected bus answer: expected response seen none");
        summarize();
    endtask
    // The master waits for the answer; only the loop bound ends a hung wait.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) hang();
        // Let an edge pass so the next call does not reassign bready in this time step.
        @(posedge ref_clk);
    endtask
    task automatic rd_reg(input logic [3:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) hang();
        // Let an edge pass so the next call does not reassign rready in this time step.
        @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd_reg(a);
        cmp("register read", {24'h0, e}, rd);
    endtask
    task automatic query(input logic [2:0] a, input target_t t, input logic w, input logic [1:0] s);
        access_area <= a;
        access_target <= t;
        repeat (2) @(posedge ref_clk);
        cmp("access width", {31'h0, w}, {31'h0, access_wide});
        cmp("access states", {30'h0, s}, {30'h0, access_states});
    endtask
    task automatic boot(input logic [2:0] m);
        op_mode <= m;
        reset <= 1'b1;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic modes(input logic g, input logic w);
        repeat (2) @(posedge ref_clk);
        cmp("port free", {31'h0, g}, {31'h0, port4_is_gpio});
        cmp("bus mode", {31'h0, w}, {31'h0, bus_wide_mode});
    endtask
    initial begin
        boot(3'h1);
        rdc(WIDTH_SEL_OFFSET, 8'hff);
        rdc(STATE_SEL_OFFSET, 8'hff);
        wr(WIDTH_SEL_OFFSET, 8'h5a);
        wr(STATE_SEL_OFFSET, 8'h3c);
        rdc(WIDTH_SEL_OFFSET, 8'h5a);
        rdc(STATE_SEL_OFFSET, 8'h3c);
        modes(1'b0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            query(i[2:0], TARGET_EXTERNAL, ((8'h5a >> i) & 8'h01) != 8'h00 ? 1'b0 : 1'b1,
                  ((8'h3c >> i) & 8'h01) != 8'h00 ? 2'h3 : 2'h2);
        end
        query(3'h5, TARGET_ONCHIP_MEM, 1'b1, 2'h2);
        query(3'h2, TARGET_INTERNAL_IO, 1'b0, 2'h3);
        $display("test area fields done");
        sw_standby <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdc(WIDTH_SEL_OFFSET, 8'h5a);
        rdc(STATE_SEL_OFFSET, 8'h3c);
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hw_standby <= 1'b0;
        rdc(WIDTH_SEL_OFFSET, 8'hff);
        rdc(STATE_SEL_OFFSET, 8'hff);
        modes(1'b1, 1'b0);
        rd_reg(4'hc);
        cmp("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, rr});
        $display("test standby done");
        boot(3'h2);
        rdc(WIDTH_SEL_OFFSET, 8'h00);
        wr(WIDTH_SEL_OFFSET, 8'hff);
        modes(1'b1, 1'b0);
        wr(WIDTH_SEL_OFFSET, 8'h7f);
        modes(1'b0, 1'b1);
        $display("test mode two done");
        boot(3'h7);
        rdc(WIDTH_SEL_OFFSET, 8'h00);
        wr(STATE_SEL_OFFSET, 8'h00);
        query(3'h0, TARGET_EXTERNAL, 1'b0, 2'h3);
        rdc(BUS_STATUS_OFFSET, 8'h02);
        $display("test single chip done");
        summarize();
    end
endmodule
